// ---- verilog/sec_attr_pkg.sv ----
// constants shared by the secure acknowledge and attribute register bank
package sec_attr_pkg;
  // register word offsets within the base page
  localparam logic [15:0] ACK_OFFSET    = 16'h8024;
  localparam logic [15:0] ATTR_OFFSET   = 16'h8028;
  // acknowledge register field positions
  localparam int ACK_NSSTALL_BIT        = 9;
  localparam int ACK_WILD_LSB           = 6;
  localparam int ACK_IFETCH_BIT         = 5;
  localparam int ACK_CMD_BIT            = 3;
  localparam int ACK_EVT_BIT            = 2;
  localparam int ACK_XLAT_BIT           = 0;
  // attribute register field positions
  localparam int TBL_SH_LSB             = 10;
  localparam int TBL_OC_LSB             = 8;
  localparam int TBL_IC_LSB             = 6;
  localparam int Q_SH_LSB               = 4;
  localparam int Q_OC_LSB               = 2;
  localparam int Q_IC_LSB               = 0;
  // attribute encodings
  localparam logic [1:0] SH_NONE        = 2'h0;
  localparam logic [1:0] SH_RSVD        = 2'h1;
  localparam logic [1:0] SH_OUTER       = 2'h2;
  localparam logic [1:0] CA_NONE        = 2'h0;
  localparam logic [1:0] CA_RSVD        = 2'h3;
  localparam logic [2:0] WILD_MAX       = 3'h4;
  localparam logic [1:0] STALL_NONE_SUP = 2'h0;
  // reset values
  localparam logic [5:0] TBL_RESET      = 6'h00;
  localparam logic [5:0] Q_RESET        = 6'h00;
  // cycles a captured target is held in pend_ff before it is acknowledged
  localparam int ACK_DELAY_CYC          = 2;
endpackage : sec_attr_pkg

// ---- verilog/secure_ctrl_ack_attr_regs.sv ----
// secure acknowledge and memory attribute register bank
`timescale 1ns/1ns
// ack fields settle three edges after a control change
// attribute groups are guarded by the acknowledged enables
module secure_ctrl_ack_attr_regs
  import sec_attr_pkg::*;
#(
  // ring count and preset attribute values
  parameter int          EXT_RINGS     = 1,
  parameter logic [5:0]  TBL_PRESET_VAL = 6'h00,
  parameter logic [5:0]  Q_PRESET_VAL   = 6'h00
) (
  // clock and reset
  input  wire logic                 core_clk_i,
  input  wire logic                 sys_rst_i,
  // register access port
  input  wire logic                 reg_rd_i,
  input  wire logic                 reg_wr_i,
  input  wire logic                 reg_secure_i,
  input  wire logic [15:0]          reg_addr_i,
  input  wire logic [31:0]          reg_wdata_i,
  output logic      [31:0]          reg_rdata_o,
  // secure control values and configuration
  input  wire logic                 secure_side_present_i,
  input  wire logic                 wildcard_supported_i,
  input  wire logic [1:0]           stall_model_support_i,
  input  wire logic                 table_attr_preset_i,
  input  wire logic                 queue_attr_preset_i,
  input  wire logic                 nonsecure_stall_disable_i,
  input  wire logic [2:0]           vmid_wildcard_i,
  input  wire logic                 secure_ifetch_fault_i,
  input  wire logic                 command_ring_enable_i,
  input  wire logic                 event_ring_enable_i,
  input  wire logic                 translation_unit_enable_i,
  input  wire logic [EXT_RINGS-1:0] ext_command_ring_enable_i,
  input  wire logic [EXT_RINGS-1:0] ext_command_ring_enable_ack_i,
  // access attribute checks from the datapath
  input  wire logic                 fetch_nonsecure_ifetch_i,
  input  wire logic                 table_type_unsupported_i,
  input  wire logic [1:0]           table_alloc_hint_i,
  input  wire logic [1:0]           queue_alloc_hint_i,
  // acknowledged state and raw stall model for the datapath
  output logic                      nonsecure_stall_barred_o,
  output logic [1:0]                nonsecure_stall_model_o,
  output logic [2:0]                invalidate_vmid_ignore_o,
  output logic                      ifetch_permission_fault_o,
  output logic                      command_ring_active_o,
  output logic                      event_ring_active_o,
  output logic                      secure_bypass_o,
  // effective memory attributes
  output logic [1:0]                table_sharing_o,
  output logic [1:0]                table_outer_cache_o,
  output logic [1:0]                table_inner_cache_o,
  output logic [1:0]                queue_sharing_o,
  output logic [1:0]                queue_outer_cache_o,
  output logic [1:0]                queue_inner_cache_o,
  output logic [1:0]                table_alloc_hint_o,
  output logic [1:0]                queue_alloc_hint_o,
  output logic                      stream_entry_fetch_fault_o
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // reserved cacheability behaves as non-cacheable
  // shared by the table and queue groups
  // encoding 3 folds to non-cacheable
  function automatic logic [1:0] eff_cache(input logic [1:0] c);
    eff_cache = (c == CA_RSVD) ? CA_NONE : c;
  endfunction : eff_cache

  // sharing with reserved and non-cacheable overrides
  // a fully non-cacheable group ignores stored sharing
  // reserved sharing folds to non-shareable
  function automatic logic [1:0] eff_share(input logic [1:0] s, input logic [1:0] oc, input logic [1:0] ic);
    if ((oc == CA_NONE) && (ic == CA_NONE)) begin
      eff_share = SH_OUTER;
    end else if (s == SH_RSVD) begin
      eff_share = SH_NONE;
    end else begin
      eff_share = s;
    end
  endfunction : eff_share

  ////////////////////////////////////////////////////////////////////////////
  // acknowledge tracking

  // every ack field follows its control field
  // once the target has held still for a few edges
  // any change of the target restarts the count
  // control targets after masking ignored fields
  logic [9:0] ctrl_tgt;
  logic [9:0] ack_ff;                          // acknowledged values
  logic [9:0] pend_ff;                         // target being settled
  logic [1:0] settle_ff;                       // update completion counter

  // build the target image
  always_comb begin
    ctrl_tgt = '0;
    // stall disable only exists without stall support
    ctrl_tgt[ACK_NSSTALL_BIT] = nonsecure_stall_disable_i &
                                (stall_model_support_i == STALL_NONE_SUP);
    // wildcard needs support and a defined value
    ctrl_tgt[ACK_WILD_LSB +: 3] = (wildcard_supported_i && vmid_wildcard_i <= WILD_MAX) ?
                                  vmid_wildcard_i : 3'h0;
    // plain enables pass straight through
    ctrl_tgt[ACK_IFETCH_BIT]  = secure_ifetch_fault_i;
    ctrl_tgt[ACK_CMD_BIT]     = command_ring_enable_i;
    ctrl_tgt[ACK_EVT_BIT]     = event_ring_enable_i;
    ctrl_tgt[ACK_XLAT_BIT]    = translation_unit_enable_i;
  end

  // ack takes new target only after it held steady
  // the settle count parks at its last value, so a
  // steady target leaves the acknowledged word alone
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      // every acknowledged field resets to zero
      ack_ff    <= 10'h0;
      pend_ff   <= 10'h0;
      settle_ff <= 2'h0;
    end else if (ctrl_tgt != pend_ff) begin
      // new target, count again from zero
      pend_ff   <= ctrl_tgt;                   // restart on any change
      settle_ff <= 2'h0;
    end else if (settle_ff == 2'(ACK_DELAY_CYC - 1)) begin
      // update complete, publish it
      ack_ff    <= pend_ff;
    end else begin
      // still settling
      settle_ff <= settle_ff + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // attribute register

  logic [5:0] tbl_ff;                          // sharing, outer, inner
  logic [5:0] q_ff;                            // sharing, outer, inner
  logic       tbl_wr_ok;                       // table group may be written
  logic       q_wr_ok;                         // queue group may be written
  logic       attr_hit;                        // secure write to attribute word
  logic       rst_q_ff;                        // reset delayed by one edge

  // hit on a secure write to the attribute word
  assign attr_hit  = reg_wr_i & reg_secure_i & secure_side_present_i &
                     (reg_addr_i == ATTR_OFFSET);
  // table group frozen while translation or its ack is on
  assign tbl_wr_ok = ~translation_unit_enable_i & ~ack_ff[ACK_XLAT_BIT];
  // queue group frozen while any ring or ring ack is on
  assign q_wr_ok   = ~command_ring_enable_i & ~ack_ff[ACK_CMD_BIT] &
                     ~event_ring_enable_i & ~ack_ff[ACK_EVT_BIT] &
                     ~(|ext_command_ring_enable_i) & ~(|ext_command_ring_enable_ack_i);

  // table group fields
  // a refused write leaves the group untouched
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      tbl_ff <= TBL_RESET;
    end else if (rst_q_ff) begin
      // preset strap only sampled once after reset
      if (table_attr_preset_i) begin
        tbl_ff <= TBL_PRESET_VAL;
      end
    end else if (attr_hit && tbl_wr_ok) begin
      // guarded software write
      tbl_ff <= reg_wdata_i[TBL_IC_LSB +: 6];
    end
  end

  // queue group fields
  // a refused write leaves the group untouched
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      q_ff <= Q_RESET;
    end else if (rst_q_ff) begin
      // preset strap only sampled once after reset
      if (queue_attr_preset_i) begin
        q_ff <= Q_PRESET_VAL;
      end
    end else if (attr_hit && q_wr_ok) begin
      // guarded software write
      q_ff <= reg_wdata_i[Q_IC_LSB +: 6];
    end
  end

  // first cycle after reset release, catches preset straps
  // plain delayed copy of reset, needs no reset itself
  always_ff @(posedge core_clk_i) begin
    rst_q_ff <= sys_rst_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read

  // read data is zero unless a secure read hits
  // an absent secure side hides both words
  logic [31:0] nxt_rdata;
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (reg_rd_i && reg_secure_i && secure_side_present_i) begin
      // both words decode on the byte offset
      case (reg_addr_i)
        ACK_OFFSET:  nxt_rdata = {22'h0, ack_ff};
        ATTR_OFFSET: nxt_rdata = {20'h0, tbl_ff, q_ff};
        default:     nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  // registered read data
  // data stands one cycle after the read strobe
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else begin
      reg_rdata_o <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // datapath controls

  // effective cacheability per group
  // reserved encodings folded before use
  logic [1:0] t_oc;
  logic [1:0] t_ic;
  logic [1:0] q_oc;
  logic [1:0] q_ic;
  assign t_oc = eff_cache(tbl_ff[TBL_OC_LSB - TBL_IC_LSB +: 2]);
  assign t_ic = eff_cache(tbl_ff[1:0]);
  assign q_oc = eff_cache(q_ff[Q_OC_LSB +: 2]);
  assign q_ic = eff_cache(q_ff[Q_IC_LSB +: 2]);

  // registered effective controls
  // outputs other than the attributes and hints follow the acknowledged state, except the stall
  // model, which is registered straight from its input
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      // reset: bypass on, sharing outer
      nonsecure_stall_barred_o  <= 1'b0;
      nonsecure_stall_model_o   <= 2'h0;
      invalidate_vmid_ignore_o  <= 3'h0;
      ifetch_permission_fault_o <= 1'b0;
      command_ring_active_o     <= 1'b0;
      event_ring_active_o       <= 1'b0;
      secure_bypass_o           <= 1'b1;
      table_sharing_o           <= SH_OUTER;
      table_outer_cache_o       <= CA_NONE;
      table_inner_cache_o       <= CA_NONE;
      queue_sharing_o           <= SH_OUTER;
      queue_outer_cache_o       <= CA_NONE;
      queue_inner_cache_o       <= CA_NONE;
      table_alloc_hint_o        <= 2'h0;
      queue_alloc_hint_o        <= 2'h0;
      stream_entry_fetch_fault_o <= 1'b0;
    end else begin
      // acknowledged controls and the raw stall model
      nonsecure_stall_barred_o  <= ack_ff[ACK_NSSTALL_BIT];
      nonsecure_stall_model_o   <= stall_model_support_i;
      invalidate_vmid_ignore_o  <= ack_ff[ACK_WILD_LSB +: 3];
      ifetch_permission_fault_o <= ack_ff[ACK_IFETCH_BIT] & fetch_nonsecure_ifetch_i;
      command_ring_active_o     <= ack_ff[ACK_CMD_BIT];
      event_ring_active_o       <= ack_ff[ACK_EVT_BIT];
      secure_bypass_o           <= ~ack_ff[ACK_XLAT_BIT];
      // effective attributes
      table_sharing_o           <= eff_share(tbl_ff[TBL_SH_LSB - TBL_IC_LSB +: 2], t_oc, t_ic);
      table_outer_cache_o       <= t_oc;
      table_inner_cache_o       <= t_ic;
      queue_sharing_o           <= eff_share(q_ff[Q_SH_LSB +: 2], q_oc, q_ic);
      queue_outer_cache_o       <= q_oc;
      queue_inner_cache_o       <= q_ic;
      // hints only pass for a cacheable group
      table_alloc_hint_o        <= (t_oc != CA_NONE || t_ic != CA_NONE) ? table_alloc_hint_i : 2'h0;
      queue_alloc_hint_o        <= (q_oc != CA_NONE || q_ic != CA_NONE) ? queue_alloc_hint_i : 2'h0;
      // fetch fault only while translating
      stream_entry_fetch_fault_o <= table_type_unsupported_i & ack_ff[ACK_XLAT_BIT];
    end
  end

endmodule : secure_ctrl_ack_attr_regs

// ---- verification/secure_ctrl_ack_attr_checker.sv ----
// assertion checker for the secure ack and attribute register bank
`timescale 1ns/1ns
module secure_ctrl_ack_attr_checker
  import sec_attr_pkg::*;
(
  // clock, reset and register port
  input wire logic        core_clk_i,
  input wire logic        sys_rst_i,
  input wire logic        reg_rd_i,
  input wire logic        reg_secure_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic [31:0] reg_rdata_o,
  // control levels and derived outputs
  input wire logic [1:0]  stall_model_support_i,
  input wire logic        translation_unit_enable_i,
  input wire logic        nonsecure_stall_barred_o,
  input wire logic        secure_bypass_o,
  input wire logic        stream_entry_fetch_fault_o,
  input wire logic [1:0]  table_sharing_o,
  input wire logic [1:0]  table_outer_cache_o,
  input wire logic [1:0]  table_inner_cache_o,
  input wire logic [1:0]  queue_sharing_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  // enable held long enough for ack and output stage
  sequence s_xlat_on;  translation_unit_enable_i [*8]; endsequence
  sequence s_xlat_off; !translation_unit_enable_i [*8]; endsequence
  chk_xlat_on_ack: assert property (s_xlat_on |-> !secure_bypass_o)
    else $error("bypass while translation held on");
  chk_xlat_off_ack: assert property (s_xlat_off |-> secure_bypass_o)
    else $error("no bypass while translation held off");
  chk_ack_not_early: assert property (s_xlat_off ##1 translation_unit_enable_i |-> secure_bypass_o [*2])
    else $error("enable acknowledged too early");
  chk_nonsec_read_zero: assert property (reg_rd_i && !reg_secure_i |=> reg_rdata_o == 32'h0000_0000)
    else $error("non-secure read not zero");
  chk_idle_rdata_zero: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0000_0000)
    else $error("read data without read");
  chk_ack_rsvd_zero: assert property (reg_rd_i && reg_addr_i == ACK_OFFSET |=>
    reg_rdata_o[31:10] == 22'h0 && !reg_rdata_o[4] && !reg_rdata_o[1]) else $error("ack reserved bits set");
  chk_attr_rsvd_zero: assert property (reg_rd_i && reg_addr_i == ATTR_OFFSET |=> reg_rdata_o[31:12] == 20'h0)
    else $error("attribute reserved bits set");
  chk_stall_rsvd: assert property ((stall_model_support_i != STALL_NONE_SUP) [*8] |-> !nonsecure_stall_barred_o)
    else $error("stall disable ack set while stall supported");
  chk_noncache_outer: assert property (table_outer_cache_o == CA_NONE && table_inner_cache_o == CA_NONE
    |-> table_sharing_o == SH_OUTER) else $error("non-cacheable table not outer shareable");
  chk_no_rsvd_enc: assert property (table_sharing_o != SH_RSVD && queue_sharing_o != SH_RSVD
    && table_outer_cache_o != CA_RSVD && table_inner_cache_o != CA_RSVD) else $error("reserved encoding output");
  chk_fetch_fault_on: assert property (stream_entry_fetch_fault_o |-> !secure_bypass_o)
    else $error("fetch fault while bypassing");
endmodule : secure_ctrl_ack_attr_checker
bind secure_ctrl_ack_attr_regs secure_ctrl_ack_attr_checker u_checker (
  .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .reg_rd_i(reg_rd_i), .reg_secure_i(reg_secure_i),
  .reg_addr_i(reg_addr_i), .reg_rdata_o(reg_rdata_o), .stall_model_support_i(stall_model_support_i),
  .translation_unit_enable_i(translation_unit_enable_i), .nonsecure_stall_barred_o(nonsecure_stall_barred_o),
  .secure_bypass_o(secure_bypass_o), .stream_entry_fetch_fault_o(stream_entry_fetch_fault_o),
  .table_sharing_o(table_sharing_o), .table_outer_cache_o(table_outer_cache_o),
  .table_inner_cache_o(table_inner_cache_o), .queue_sharing_o(queue_sharing_o));

// ---- verification/tb_secure_ctrl_ack_attr_regs.sv ----
// self-checking bench for the secure ack and attribute register bank
`timescale 1ns/1ns
module tb_secure_ctrl_ack_attr_regs;
  import sec_attr_pkg::*;
  // counters, stimulus and observed outputs
  int          bad_count   = 0;
  int          check_count = 0;
  logic        clk = 1'h0, rst = 1'h1, rd = 1'h0, wr = 1'h0, sec = 1'h1, pres = 1'h1, wsup = 1'h1;
  logic        nss = 1'h0, secure_ifetch_fault = 1'h0, cmd = 1'h0, evt = 1'h0, xl = 1'h0, ext = 1'h0, exta = 1'h0;
  logic        fe = 1'h0, tu = 1'h0, bar, ifl, byp, ftl, cra, era;
  logic [1:0]  sms = 2'h0, tsh, toc, tic, qsh, qoc, qic, smo, tah, qah;
  logic [2:0]  vmid_wildcard = 3'h0, vig;
  logic [15:0] addr = 16'h0000;
  logic [31:0] wd = 32'h0000_0000, rdata;
  // attribute words written and effective outputs expected
  logic [11:0] wv [3] = '{12'h5A5, 12'hFFF, 12'hE5E};
  logic [11:0] ev [3] = '{12'h1A5, 12'h820, 12'hE42};
  secure_ctrl_ack_attr_regs u_dut (
    .core_clk_i(clk), .sys_rst_i(rst), .reg_rd_i(rd), .reg_wr_i(wr), .reg_secure_i(sec),
    .reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rdata), .secure_side_present_i(pres),
    .wildcard_supported_i(wsup), .stall_model_support_i(sms), .table_attr_preset_i(1'h0),
    .queue_attr_preset_i(1'h0), .nonsecure_stall_disable_i(nss), .vmid_wildcard_i(vmid_wildcard),
    .secure_ifetch_fault_i(secure_ifetch_fault), .command_ring_enable_i(cmd), .event_ring_enable_i(evt),
    .translation_unit_enable_i(xl), .ext_command_ring_enable_i(ext), .ext_command_ring_enable_ack_i(exta),
    .fetch_nonsecure_ifetch_i(fe), .table_type_unsupported_i(tu), .table_alloc_hint_i(2'h3),
    .queue_alloc_hint_i(2'h3), .nonsecure_stall_barred_o(bar), .nonsecure_stall_model_o(smo),
    .invalidate_vmid_ignore_o(vig), .ifetch_permission_fault_o(ifl), .command_ring_active_o(cra),
    .event_ring_active_o(era), .secure_bypass_o(byp), .table_sharing_o(tsh), .table_outer_cache_o(toc),
    .table_inner_cache_o(tic), .queue_sharing_o(qsh), .queue_outer_cache_o(qoc), .queue_inner_cache_o(qic),
    .table_alloc_hint_o(tah), .queue_alloc_hint_o(qah), .stream_entry_fetch_fault_o(ftl));
  // 50 MHz clock
  initial forever #10 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one-cycle write strobe, taken at the next rising edge, then one idle cycle
  task automatic reg_wr(input logic [15:0] a, input logic [31:0] d, input logic s);
    addr = a; wd = d; sec = s; wr = 1'h1;
    @(negedge clk);
    wr = 1'h0; sec = 1'h1;
    @(negedge clk);
  endtask : reg_wr
  // one-cycle read strobe, data checked the cycle after
  task automatic reg_rd(input logic [15:0] a, input logic s, input logic [31:0] exp);
    addr = a; sec = s; rd = 1'h1;
    @(negedge clk);
    rd = 1'h0; sec = 1'h1;
    chk(rdata, exp);
    @(negedge clk);
  endtask : reg_rd
  task automatic conclude;
    if (bad_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////////
  // main sequence, all inputs change on the falling edge
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'h0;
    repeat (2) @(negedge clk);
    reg_rd(ACK_OFFSET, 1'h1, 32'h0);
    reg_rd(ATTR_OFFSET, 1'h1, 32'h0);
    chk({tsh, qsh, tah, qah}, 8'hA0);
    reg_wr(ATTR_OFFSET, 32'h0000_05A5, 1'h0);
    reg_rd(ATTR_OFFSET, 1'h0, 32'h0);
    reg_rd(ATTR_OFFSET, 1'h1, 32'h0);
    // encodings incl. reserved values, high bits dropped
    for (int i = 0; i < 3; i++) begin
      reg_wr(ATTR_OFFSET, {20'hFFFFF, wv[i]}, 1'h1);
      reg_rd(ATTR_OFFSET, 1'h1, {20'h0, wv[i]});
      chk({tsh, toc, tic, qsh, qoc, qic}, ev[i]);
    end
    chk({tah, qah}, 4'hF);
    // all enables on, ack must lag the control change
    {nss, vmid_wildcard, secure_ifetch_fault, cmd, evt, xl, tu, fe} = {1'h1, 3'h4, 6'h3F};
    reg_rd(ACK_OFFSET, 1'h1, 32'h0);
    reg_rd(ACK_OFFSET, 1'h1, 32'h0);
    repeat (5) @(negedge clk);
    reg_rd(ACK_OFFSET, 1'h1, 32'h0000_032D);
    chk({bar, ifl, byp, ftl}, 4'hD);
    chk({cra, era, vig, smo}, 7'h70);
    reg_wr(ACK_OFFSET, 32'h0000_0000, 1'h1);
    reg_rd(ACK_OFFSET, 1'h1, 32'h0000_032D);
    reg_rd(ACK_OFFSET, 1'h0, 32'h0);
    reg_wr(ATTR_OFFSET, 32'h0000_0000, 1'h1);
    reg_rd(ATTR_OFFSET, 1'h1, 32'h0000_0E5E);
    // stall model supported, every wildcard value
    sms = 2'h1;
    for (int v = 0; v < 8; v++) begin
      vmid_wildcard = v[2:0];
      repeat (6) @(negedge clk);
      reg_rd(ACK_OFFSET, 1'h1, 32'h2D | ((v <= 4) ? (v << 6) : 0));
      chk({smo, vig}, 5'h8 + ((v <= 4) ? v : 0));
    end
    {wsup, vmid_wildcard} = {1'h0, 3'h4};
    repeat (6) @(negedge clk);
    reg_rd(ACK_OFFSET, 1'h1, 32'h0000_002D);
    chk({smo, vig}, 5'h8);
    // release the guards one group at a time
    xl = 1'h0;
    repeat (6) @(negedge clk);
    reg_wr(ATTR_OFFSET, 32'h0000_0000, 1'h1);
    reg_rd(ATTR_OFFSET, 1'h1, 32'h0000_001E);
    {cmd, evt, ext} = 3'h1;
    repeat (6) @(negedge clk);
    reg_wr(ATTR_OFFSET, 32'h0000_0FFF, 1'h1);
    reg_rd(ATTR_OFFSET, 1'h1, 32'h0000_0FDE);
    {ext, exta} = 2'h1;
    reg_wr(ATTR_OFFSET, 32'h0000_0000, 1'h1);
    reg_rd(ATTR_OFFSET, 1'h1, 32'h0000_001E);
    exta = 1'h0;
    reg_wr(ATTR_OFFSET, 32'h0000_0000, 1'h1);
    reg_rd(ATTR_OFFSET, 1'h1, 32'h0);
    reg_rd(16'h8030, 1'h1, 32'h0);
    pres = 1'h0;
    reg_rd(ACK_OFFSET, 1'h1, 32'h0);
    conclude();
  end
endmodule : tb_secure_ctrl_ack_attr_regs
